// ===== core/ee_i2c_eeprom.sv
// How it works
// - device address byte is type code, three select bits, then read/write bit.
// - respond only when select bits match the three select pins.
// - read/write bit 1 means read, 0 means write.
// - an open select pin is not pulled low inside; unused select pins must be tied low.
// - address byte gives bits 7..0, or 6..0 on the small variant.
// - receive data sampled on rising serial clock edges.
// - transmit data changes on falling serial clock edges.
// - byte write is start, device, address, data, stop; each byte acknowledged.
// - valid stop after a write starts a timed cycle; bus ignored meanwhile.
// - page write latches up to eight data bytes for one cycle.
// - address counter increments within the page after each received write data byte, wrapping to the page start.
// - write starts only if stop lands right after an acknowledge.
// - matching address left unacknowledged while write cycle busy.
// - during power-on reset all commands ignored, no write.
// - counter holds last accessed address plus one.
// - read request: acknowledge, send byte at counter, then increment.
// - acknowledged read byte leads to next byte and increment.
// - counter wraps to zero past the last location.
// - data falling with clock high is start, rising is stop.
// - no acknowledge after a sent byte returns device to standby.
// - write protect high blocks every write to the array.
`include "ee_params.svh"
`default_nettype none
module ee_i2c_eeprom #(
  parameter int ADDR_BITS = 8,
  parameter int WRITE_CYCLES = `EE_WRITE_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // power-on reset from the supply monitor
  input wire logic por,
  // straps (tie low when unconnected)
  input wire logic device_select_pin_0,
  input wire logic device_select_pin_1,
  input wire logic device_select_pin_2,
  input wire logic write_protect,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // status
  output logic write_busy
);
  localparam int DEPTH = 1 << ADDR_BITS;
  localparam int PAW = `EE_PAGE_AW;

  // ****************
  // pin sampling
  // ****************
  ee_pkg::ee_bus_t bus_raw;
  ee_pkg::ee_bus_t bus_s;
  ee_pkg::ee_bus_t bus_p_q;
  logic por_s1_q, por_s2_q;
  assign bus_raw = '{scl: scl_in, sda: sda_in};
  ee_sync u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_in(bus_raw),
    .pin_out(bus_s)
  );
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_p_q <= 2'h3;
      por_s1_q <= 1'b1;
      por_s2_q <= 1'b1;
    end else begin
      bus_p_q <= bus_s;
      por_s1_q <= por;
      por_s2_q <= por_s1_q;
    end
  end
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = bus_s.scl & ~bus_p_q.scl;
  assign scl_fall = ~bus_s.scl & bus_p_q.scl;
  assign start_cond = bus_s.scl & bus_p_q.scl & bus_p_q.sda & ~bus_s.sda;
  assign stop_cond = bus_s.scl & bus_p_q.scl & ~bus_p_q.sda & bus_s.sda;

  // ****************
  // protocol state
  // ****************
  ee_pkg::ee_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] pbase_q, pbase_d;
  logic [PAW-1:0] pcnt_q, pcnt_d;
  logic [`EE_PAGE_BYTES-1:0] pvld_q, pvld_d;
  logic [7:0] pdat_q [`EE_PAGE_BYTES];
  logic [7:0] pdat_d [`EE_PAGE_BYTES];
  logic ack_q, ack_d;
  logic drv_q, drv_d;
  logic arm_q, arm_d;
  logic wdone_q, wdone_d;
  logic [31:0] wtmr_q, wtmr_d;
  logic [PAW:0] wix_q, wix_d;
  logic busy_q, busy_d;
  logic [7:0] rd_data;
  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] addr_mask;
  logic sel_match;
  logic [2:0] sel_pins;

  assign addr_mask = 8'((DEPTH) - 1);
  assign sel_pins = {device_select_pin_2, device_select_pin_1, device_select_pin_0};
  assign sel_match = (sh_q[7:4] == `EE_TYPE_CODE) && (sh_q[3:1] == sel_pins);

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    pbase_d = pbase_q;
    pcnt_d = pcnt_q;
    pvld_d = pvld_q;
    pdat_d = pdat_q;
    ack_d = ack_q;
    drv_d = drv_q;
    arm_d = arm_q;
    wdone_d = wdone_q;
    wtmr_d = wtmr_q;
    wix_d = wix_q;
    busy_d = busy_q;
    mem_we = 1'b0;
    mem_wa = pbase_q | 8'(wix_q[PAW-1:0]);
    // self-timed cycle: copy latches to the array, then wait out the time
    if (busy_q) begin
      if (wix_q < (PAW + 1)'(`EE_PAGE_BYTES)) begin
        mem_we = pvld_q[wix_q[PAW-1:0]];
        wix_d = wix_q + 1'b1;
      end
      if (wtmr_q == 32'(WRITE_CYCLES - 1)) begin
        busy_d = 1'b0;
        pvld_d = '0;
      end else begin
        wtmr_d = wtmr_q + 32'h1;
      end
    end
    // bus ignored while busy or held in power-on reset
    if (busy_q || por_s2_q) begin
      st_d = ee_pkg::EE_IDLE;
      drv_d = 1'b0;
      arm_d = 1'b0;
    end else if (start_cond) begin
      st_d = ee_pkg::EE_DEV;
      bit_d = 4'hf; // scl fall closing the start wraps this to bit 0
      drv_d = 1'b0;
      arm_d = 1'b0;
      pvld_d = '0;
    end else if (stop_cond) begin
      st_d = ee_pkg::EE_IDLE;
      drv_d = 1'b0;
      // only a stop in the period right after a data acknowledge writes
      if (arm_q && (pvld_q != '0) && !write_protect) begin
        busy_d = 1'b1;
        wtmr_d = 32'h0;
        wix_d = '0;
      end
      arm_d = 1'b0;
    end else if (st_q != ee_pkg::EE_IDLE) begin
      if (scl_rise) begin
        if (bit_q < `EE_BITS_PER_BYTE) begin
          // the 10th period's rise must not disarm a following stop
          sh_d = {sh_q[6:0], bus_s.sda};
        end else if (st_q == ee_pkg::EE_RDATA) begin
          ack_d = ~bus_s.sda;
        end
      end else if (scl_fall) begin
        bit_d = bit_q + 4'h1;
        drv_d = 1'b0;
        arm_d = 1'b0;
        if (bit_q == `EE_BITS_PER_BYTE - 4'h1) begin
          // ninth clock: acknowledge what was received
          case (st_q)
            ee_pkg::EE_DEV: drv_d = sel_match;
            ee_pkg::EE_ADDR, ee_pkg::EE_WDATA: drv_d = 1'b1;
            default: drv_d = 1'b0;
          endcase
          if (st_q == ee_pkg::EE_DEV && !sel_match) begin
            st_d = ee_pkg::EE_IDLE;
          end
          if (st_q == ee_pkg::EE_ADDR) begin
            cnt_d = sh_q & addr_mask;
            pbase_d = sh_q & addr_mask & ~8'(`EE_PAGE_BYTES - 1);
            pcnt_d = sh_q[PAW-1:0];
          end
          if (st_q == ee_pkg::EE_WDATA) begin
            pdat_d[pcnt_q] = sh_q;
            pvld_d[pcnt_q] = 1'b1;
            pcnt_d = pcnt_q + 1'b1;
            cnt_d = (pbase_q | 8'(pcnt_q + 1'b1)) & addr_mask;
          end
          if (st_q == ee_pkg::EE_RDATA) begin
            drv_d = 1'b0;
          end
        end else if (bit_q == `EE_ACK_BIT - 4'h1) begin
          // end of ninth clock: next byte begins
          bit_d = 4'h0;
          case (st_q)
            ee_pkg::EE_DEV: begin
              if (sh_q[0]) begin
                st_d = ee_pkg::EE_RDATA;
                sh_d = rd_data;
                cnt_d = (cnt_q + 8'h1) & addr_mask;
                drv_d = ~rd_data[7];
              end else begin
                st_d = ee_pkg::EE_ADDR;
              end
            end
            ee_pkg::EE_ADDR: st_d = ee_pkg::EE_WDATA;
            ee_pkg::EE_WDATA: arm_d = 1'b1;
            ee_pkg::EE_RDATA: begin
              if (ack_q) begin
                sh_d = rd_data;
                cnt_d = (cnt_q + 8'h1) & addr_mask;
                drv_d = ~rd_data[7];
              end else begin
                st_d = ee_pkg::EE_IDLE;
              end
            end
            default: st_d = ee_pkg::EE_IDLE;
          endcase
        end else if (st_q == ee_pkg::EE_RDATA) begin
          // shift next bit out; open drain drives only the zeros
          // the rise already rotated the driven bit round, next one is on top
          drv_d = ~sh_q[7];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= ee_pkg::EE_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      cnt_q <= 8'h00;
      pbase_q <= 8'h00;
      pcnt_q <= '0;
      pvld_q <= '0;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
      arm_q <= 1'b0;
      wdone_q <= 1'b0;
      wtmr_q <= 32'h0;
      wix_q <= '0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      pbase_q <= pbase_d;
      pcnt_q <= pcnt_d;
      pvld_q <= pvld_d;
      ack_q <= ack_d;
      drv_q <= drv_d;
      arm_q <= arm_d;
      wdone_q <= wdone_d;
      wtmr_q <= wtmr_d;
      wix_q <= wix_d;
      busy_q <= busy_d;
    end
  end
  // page latches carry data only, no reset needed
  always_ff @(posedge clk_sys) begin
    pdat_q <= pdat_d;
  end

  // ****************
  // array
  // ****************
  ee_mem #(.DEPTH(`EE_DEPTH_256)) u_mem (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_addr(mem_wa & addr_mask),
    .wr_data(pdat_q[wix_q[PAW-1:0]]),
    .rd_addr(cnt_q),
    .rd_data(rd_data)
  );

  assign sda_out = 1'b0;
  assign sda_oe = drv_q;
  assign write_busy = busy_q;
endmodule
`default_nettype wire

// ===== core/ee_mem.sv
`default_nettype none
module ee_mem #(
  parameter int DEPTH = 256
) (
  // clock
  input wire logic clk_sys,
  // write port
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [DEPTH];
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data <= mem_q[rd_addr];
  end
endmodule
`default_nettype wire

// ===== core/ee_params.svh
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH
// device type code in the upper nibble of the device address byte
`define EE_TYPE_CODE 4'ha
`define EE_PAGE_BYTES 8
`define EE_PAGE_AW 3
`define EE_DEPTH_256 256
`define EE_BITS_PER_BYTE 4'h8
`define EE_ACK_BIT 4'h9
// internal write cycle time in ms and system clock in MHz
`define EE_WRITE_CYCLE_MS 10
`define EE_CLK_MHZ 250
`define EE_WRITE_CYCLES (`EE_WRITE_CYCLE_MS * 1000 * `EE_CLK_MHZ)
`endif

// ===== core/ee_pkg.sv
`default_nettype none
package ee_pkg;
  typedef enum logic [2:0] {
    EE_IDLE = 3'h0,
    EE_DEV = 3'h1,
    EE_ADDR = 3'h2,
    EE_WDATA = 3'h3,
    EE_RDATA = 3'h4
  } ee_state_t;
  // sampled bus pins travelling together
  typedef struct packed {
    logic scl;
    logic sda;
  } ee_bus_t;
endpackage
`default_nettype wire

// ===== core/ee_sync.sv
`default_nettype none
module ee_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // raw pins in, synchronised out
  input wire ee_pkg::ee_bus_t pin_in,
  output ee_pkg::ee_bus_t pin_out
);
  ee_pkg::ee_bus_t s1_q;
  ee_pkg::ee_bus_t s2_q;
  // idle bus is high, so reset to high to avoid a false start
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
    end
  end
  assign pin_out = s2_q;
endmodule
`default_nettype wire

// ===== sim/ee_bus_master.sv
`default_nettype none
module ee_bus_master (
  // clock
  input wire logic clk_sys,
  // bus
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // scl period is 8 system clocks, 32 ns
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // data moves three clocks into the four-clock low phase, one clock before scl rises
  task automatic bit_io(input logic v, output logic s);
    w(3);
    sda_m = v;
    w(1);
    scl = 1'b1;
    w(4);
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    w(3);
    sda_m = 1'b1;
    w(1);
    scl = 1'b1;
    w(4);
    sda_m = 1'b0;
    w(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    w(3);
    sda_m = 1'b0;
    w(1);
    scl = 1'b1;
    w(4);
    sda_m = 1'b1;
    w(4);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(!more, s);
  endtask
endmodule
`default_nettype wire

// ===== sim/ee_eeprom_assertions.sv
`default_nettype none
module ee_eeprom_assertions #(
  parameter int WRITE_CYCLES = 200
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // power and straps
  input wire logic por,
  input wire logic device_select_pin_0,
  input wire logic device_select_pin_1,
  input wire logic device_select_pin_2,
  input wire logic write_protect,
  // bus and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  logic [31:0] busy_cnt_d;
  logic [31:0] busy_cnt_q;
  always_comb begin
    busy_cnt_d = write_busy ? busy_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys) begin
    busy_cnt_q <= srst ? 32'h0 : busy_cnt_d;
  end
  // ************
  // assertions
  // ************
  a_drain_only: assert property (sda_out == 1'b0) else $error("sda driven high");
  a_por_quiet: assert property (por [*4] |-> !sda_oe && !$rose(write_busy)) else $error("active in por");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in, 3)) else $error("sda moved, scl high");
  a_oe_stable: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*6]) else $error("sda bit too short");
  a_busy_len: assert property ($fell(write_busy) |-> busy_cnt_q == 32'(WRITE_CYCLES)) else $error("busy length");
  a_busy_quiet: assert property (write_busy |-> !sda_oe) else $error("ack while busy");
  a_busy_stop: assert property ($rose(write_busy) |-> scl_in && sda_in && !por) else $error("busy not at stop");
  a_reset_idle: assert property ($past(srst) |-> !sda_oe && !write_busy) else $error("not idle after reset");
  c_write: cover property ($rose(write_busy));
  c_ack: cover property ($rose(sda_oe));
  c_done: cover property ($fell(write_busy));
endmodule
`default_nettype wire

// ===== sim/tb.sv
`include "ee_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 200;
  logic clk_sys;
  logic srst;
  logic por;
  logic wp;
  logic [2:0] sel;
  logic scl;
  logic sda_m;
  logic sda_out;
  logic sda_oe;
  logic write_busy;
  logic sda_line;
  logic ack;
  int n_errors;
  int num_checks;
  logic [7:0] nodata[$];
  // address, data written and read back
  logic [15:0] rows [3] = '{16'h005a, 16'hffa5, 16'h373c};
  // pull-up plus open drain
  assign sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
  ee_i2c_eeprom #(.ADDR_BITS(8), .WRITE_CYCLES(WC)) ee_i2c_eeprom_inst (
    .clk_sys(clk_sys), .srst(srst), .por(por), .device_select_pin_0(sel[0]),
    .device_select_pin_1(sel[1]), .device_select_pin_2(sel[2]), .write_protect(wp),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy));
  ee_bus_master ee_bus_master_inst (.clk_sys(clk_sys), .scl(scl), .sda_m(sda_m), .sda(sda_line));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic dev(input logic [2:0] s, input logic rw, output logic a);
    ee_bus_master_inst.start();
    ee_bus_master_inst.wbyte({`EE_TYPE_CODE, s, rw}, a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$], input logic go);
    logic k;
    dev(sel, 1'b0, k);
    chk(k, "no device ack");
    ee_bus_master_inst.wbyte(a, k);
    chk(k, "no address ack");
    foreach (d[i]) begin
      ee_bus_master_inst.wbyte(d[i], k);
      chk(k, "no data ack");
    end
    if (go) begin
      ee_bus_master_inst.stop();
    end
  endtask
  task automatic poll();
    logic k;
    dev(sel, 1'b0, k);
    chk(!k, "ack while writing");
    for (int i = 0; i < 20 && !k; i++) begin
      ee_bus_master_inst.stop();
      dev(sel, 1'b0, k);
    end
    chk(k, "no ack after write");
    ee_bus_master_inst.stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic rnd, input logic [7:0] e[$]);
    logic k;
    logic [7:0] b;
    if (rnd) begin
      wr(a, nodata, 1'b0);
    end
    dev(sel, 1'b1, k);
    chk(k, "no read ack");
    foreach (e[i]) begin
      ee_bus_master_inst.rbyte(i < e.size() - 1, b);
      chk(b === e[i], "read data");
    end
    ee_bus_master_inst.stop();
  endtask
  initial begin
    srst = 1'b1;
    por = 1'b1;
    wp = 1'b0;
    sel = 3'h5;
    n_errors = 0;
    num_checks = 0;
    repeat (8) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    chk(sda_oe === 1'b0 && write_busy === 1'b0, "reset state");
    dev(sel, 1'b0, ack);
    chk(!ack, "ack in power-on reset");
    ee_bus_master_inst.stop();
    por = 1'b0;
    repeat (4) @(negedge clk_sys);
    foreach (rows[i]) begin
      wr(rows[i][15:8], {rows[i][7:0]}, 1'b1);
      poll();
      rd(rows[i][15:8], 1'b1, {rows[i][7:0]});
    end
    // nine bytes from 7d: the ninth overwrites 7d
    wr(8'h7d, {8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hc8}, 1'b1);
    poll();
    rd(8'h78, 1'b1, {8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hc8, 8'hc1, 8'hc2});
    rd(8'hff, 1'b1, {8'ha5});
    rd(8'h00, 1'b0, {8'h5a});
    wr(8'h37, nodata, 1'b1);
    repeat (4) @(negedge clk_sys);
    chk(write_busy === 1'b0, "write after address only");
    rd(8'h00, 1'b0, {8'h3c});
    dev(3'h4, 1'b0, ack);
    chk(!ack, "ack on other select");
    ee_bus_master_inst.stop();
    wp = 1'b1;
    wr(8'h00, {8'h11}, 1'b1);
    repeat (WC + 20) @(negedge clk_sys);
    wp = 1'b0;
    rd(8'h00, 1'b1, {8'h5a});
    end_of_test();
  end
  initial begin
    repeat (40000) @(negedge clk_sys);
    chk(1'b0, "timeout");
    end_of_test();
  end
endmodule
bind ee_i2c_eeprom ee_eeprom_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) ee_eeprom_assertions_inst (
  .clk_sys(clk_sys), .srst(srst), .por(por), .device_select_pin_0(device_select_pin_0),
  .device_select_pin_1(device_select_pin_1), .device_select_pin_2(device_select_pin_2),
  .write_protect(write_protect), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_busy(write_busy));
`default_nettype wire
